// ### design/spb_defines.vh
// Offsets, field positions, masks and reset values of the serial port register banks.
// Assumes it is included by its bare name from every design file of the block.
`ifndef SPB_DEFINES_VH
`define SPB_DEFINES_VH

// Offsets inside the eight-location window, given as register index
`define SPB_OFS_DATA        3'h0
`define SPB_OFS_IER         3'h1
`define SPB_OFS_EVT         3'h2
`define SPB_OFS_LCBS        3'h3
`define SPB_OFS_MCR         3'h4
`define SPB_OFS_LSR         3'h5
`define SPB_OFS_MSR         3'h6
`define SPB_OFS_AUX         3'h7

// Interrupt registers, above the banked window
`define SPB_IDX_IRQ_STATUS  4'h8
`define SPB_IDX_IRQ_MASK    4'h9

// Bank numbers
`define SPB_BANK0           3'h0
`define SPB_BANK1           3'h1
`define SPB_BANK2           3'h2
`define SPB_BANK3           3'h3
`define SPB_BANK4           3'h4
`define SPB_BANK5           3'h5
`define SPB_BANK6           3'h6
`define SPB_BANK7           3'h7

// Bank selector: flag bit, second-level bit and bits 5-2 codes
`define SPB_BANK_SELECT_FLAG_BIT        7
`define SPB_SEL_HI_BIT      6
`define SPB_SEL_CODE_BANK2  4'h8
`define SPB_SEL_CODE_BANK3  4'h9
`define SPB_SEL_CODE_BANK4  4'ha
`define SPB_SEL_CODE_BANK5  4'hb
`define SPB_SEL_CODE_BANK6  4'hc
`define SPB_SEL_CODE_BANK7  4'hd

// Field masks
`define SPB_EXT_BIT         0
`define SPB_IER_BASE_MASK   8'h0f
`define SPB_IER_DMA_MASK    8'h10
`define SPB_IER_TXEMP_MASK  8'h20
`define SPB_MCR_STD_MASK    8'h1f
`define SPB_MCR_EXT_MASK    8'h0b
`define SPB_EXTENDED_CTRL_ONE_MASK      8'hb1
`define SPB_EXTENDED_CTRL_TWO_MASK      8'hb0
`define SPB_TX_FIFO_LEVEL_MASK      8'h3f
`define SPB_RX_FIFO_LEVEL_MASK      8'h1f
`define SPB_LINE_MASK       8'h7f

// Reset values
`define SPB_RST_BYTE        8'h00
`define SPB_RST_WORD        16'h0000
`define SPB_RST_EV          4'h0

// Interrupt event bits
`define SPB_EV_W            4
`define SPB_EV_RX           0
`define SPB_EV_TX           1
`define SPB_EV_BANK         2
`define SPB_EV_REFUSED      3

`endif

// ### design/spb_bank_decode.v
// Bank selector decoder: maps the stored select byte to a bank number.
// Assumes the select byte comes from a register on the same clock.
`include "spb_defines.vh"
`default_nettype none

module spb_bank_decode
(
	// Stored line control / bank select byte
	input  wire [7:0] sel_byte,
	// Decoded bank
	output reg  [2:0] bank,
	output reg        bank_valid
);

////////////////////////////////////////////////////////////////////////////////
// Decode; codes outside the table select no bank, so window reads other than offset 03h return zero
always @*
begin
	bank = `SPB_BANK0;
	bank_valid = 1'b1;
	if (!sel_byte[`SPB_BANK_SELECT_FLAG_BIT])
		bank = `SPB_BANK0; // R4
	else if (!sel_byte[`SPB_SEL_HI_BIT] || sel_byte[1] || sel_byte[0])
		bank = `SPB_BANK1; // R4
	else
	begin
		case (sel_byte[5:2])
			`SPB_SEL_CODE_BANK2: bank = `SPB_BANK2;
			`SPB_SEL_CODE_BANK3: bank = `SPB_BANK3;
			`SPB_SEL_CODE_BANK4: bank = `SPB_BANK4;
			`SPB_SEL_CODE_BANK5: bank = `SPB_BANK5;
			`SPB_SEL_CODE_BANK6: bank = `SPB_BANK6;
			`SPB_SEL_CODE_BANK7: bank = `SPB_BANK7;
			default:             bank_valid = 1'b0;
		endcase
	end
end

endmodule
`default_nettype wire

// ### design/spb_irq.v
// Sticky event status, mask and level interrupt of the register bank.
// Assumes events are one-cycle pulses on the same clock.
`include "spb_defines.vh"
`default_nettype none

module spb_irq
(
	// Clock and reset
	input  wire                 mclk,
	input  wire                 rst_b,
	// Events
	input  wire [`SPB_EV_W-1:0] events,
	// Software access
	input  wire                 clear_wr,
	input  wire                 mask_wr,
	input  wire [`SPB_EV_W-1:0] wr_data,
	// State
	output reg  [`SPB_EV_W-1:0] status,
	output reg  [`SPB_EV_W-1:0] mask,
	output reg                  irq
);

wire [`SPB_EV_W-1:0] clear_bits;
wire [`SPB_EV_W-1:0] next_status;
wire [`SPB_EV_W-1:0] next_mask;

// Set wins over a write-one clear in the same cycle
assign clear_bits  = clear_wr ? wr_data : `SPB_RST_EV;
assign next_status = (status & ~clear_bits) | events;
assign next_mask   = mask_wr ? wr_data : mask;

////////////////////////////////////////////////////////////////////////////////
// Status, mask and level output, the output tracks next state to avoid a lag
always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		status <= `SPB_RST_EV;
		mask   <= `SPB_RST_EV;
		irq    <= 1'b0;
	end
	else
	begin
		status <= next_status;
		mask   <= next_mask;
		irq    <= |(next_status & next_mask);
	end
end

endmodule
`default_nettype wire

// ### design/spb_regs.v
// UART register banks of one serial port, behind an Avalon-MM slave.
// Assumes the UART core runs on mclk and hands over levels and pulses directly.
//
// Added by the designer: the Avalon-MM register port.
`include "spb_defines.vh"
`default_nettype none

// Operation
// R1 - Four banks of eight byte registers share one window, offsets 00h to 07h
// R2 - Line control / bank select sits at offset 03h in every bank
// R3 - A written byte with bit 7 set holds a bank selector in bits 6-0
// R4 - Selector decode: bit7 low bank 0, 10x or 11 with bits 1/0 bank 1, codes 2-7
// R5 - Bank 0 offset 00h reads received data, writes load transmit data
// R6 - Bank 0 offset 02h reads event identification, writes the write-only FIFO control
// R7 - Bank 1 holds legacy divisor low/high at 00h/01h; 02h and 04h-07h reserved
// R8 - Bank 2: divisor 00h/01h, extended control 02h and 04h, FIFO levels 06h/07h
// R9 - Bank 3: read-only revision 00h, line control copy 01h, FIFO control copy 02h
// R10 - Interrupt enable bits 3-0; extended adds bit 5; bit 4 DMA on second port
// R11 - Bank 0 offset 07h is scratch normally, auxiliary status/control when extended
// R12 - Revision register: module identifier bits 7-4, revision bits 3-0
// R13 - Writes to read-only or reserved places are ignored; reserved reads zero
module spb_regs
#(
	parameter SECOND_PORT = 1'b0,
	// Arbitrary identification values
	parameter [3:0] MODULE_ID = 4'h1,
	parameter [3:0] REVISION  = 4'h0
)
(
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_b,
	// Avalon-MM slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [3:0]  avs_byteenable,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Interrupt
	output reg         irq,
	// Receive side of the UART core
	input  wire [7:0]  rx_data,
	input  wire        rx_valid,
	output reg         rx_pop,
	// Transmit side of the UART core
	output reg  [7:0]  tx_data,
	output reg         tx_load,
	// FIFO control
	output reg  [7:0]  fifo_ctrl,
	output reg         fifo_ctrl_load,
	input  wire [7:0]  tx_fifo_level,
	input  wire [7:0]  rx_fifo_level,
	// Status from the UART core
	input  wire [7:0]  event_ident,
	input  wire [7:0]  link_status,
	input  wire [7:0]  modem_status,
	input  wire [7:0]  aux_status,
	// Control to the UART core
	output reg  [7:0]  line_ctrl,
	output reg  [7:0]  irq_enable,
	output reg  [7:0]  modem_mode_ctrl,
	output reg  [7:0]  aux_status_ctrl,
	output reg  [15:0] legacy_divisor,
	output reg  [15:0] ext_divisor,
	output reg  [7:0]  extended_ctrl_one,
	output reg  [7:0]  extended_ctrl_two
);

////////////////////////////////////////////////////////////////////////////////
// Internal state

reg  [7:0]            bank_select;
reg  [7:0]            scratch_byte;
reg  [7:0]            next_rdata;
reg                   wr_legal;
reg                   bank_write;
reg                   tx_accepted;
reg                   refused;
wire [2:0]            bank;
wire                  bank_valid;
wire                  req;
wire                  rd_take;
wire                  wr_take;
wire [2:0]            offset;
wire [7:0]            wbyte;
wire                  ext_mode;
wire [7:0]            ier_mask;
wire [7:0]            mcr_mask;
wire [`SPB_EV_W-1:0]  events;
wire [`SPB_EV_W-1:0]  irq_status;
wire [`SPB_EV_W-1:0]  irq_mask;
wire                  irq_next;
wire                  irq_area;

// Request handshake terms
assign req      = avs_read | avs_write;
assign rd_take  = avs_read & ~avs_waitrequest;
assign wr_take  = avs_write & ~avs_waitrequest & avs_byteenable[0];
assign offset   = avs_address[2:0];
assign irq_area = avs_address[3];
assign wbyte    = avs_writedata[7:0];

// Mode terms; extended mode follows the extended control select bit
assign ext_mode = extended_ctrl_one[`SPB_EXT_BIT];
assign ier_mask = ext_mode ?
	(`SPB_IER_BASE_MASK | `SPB_IER_TXEMP_MASK | (SECOND_PORT ? `SPB_IER_DMA_MASK : `SPB_RST_BYTE)) :
	`SPB_IER_BASE_MASK; // R10
assign mcr_mask = ext_mode ? `SPB_MCR_EXT_MASK : `SPB_MCR_STD_MASK;

////////////////////////////////////////////////////////////////////////////////
// Bank decode of the stored select byte

spb_bank_decode u_decode
(
	.sel_byte   (bank_select),
	.bank       (bank),
	.bank_valid (bank_valid)
);

////////////////////////////////////////////////////////////////////////////////
// Read mux and write legality for the addressed location
always @*
begin
	next_rdata = `SPB_RST_BYTE;
	wr_legal   = 1'b0;
	if (irq_area)
	begin
		case (avs_address)
			`SPB_IDX_IRQ_STATUS:
			begin
				next_rdata = {4'h0, irq_status};
				wr_legal   = 1'b1;
			end
			`SPB_IDX_IRQ_MASK:
			begin
				next_rdata = {4'h0, irq_mask};
				wr_legal   = 1'b1;
			end
			default:
				next_rdata = `SPB_RST_BYTE;
		endcase
	end
	else if (offset == `SPB_OFS_LCBS)
	begin
		// Reachable from any bank, including undecoded ones
		next_rdata = bank_select; // R2
		wr_legal   = 1'b1; // R2
	end
	else if (bank_valid)
	begin
		case (bank) // R1
			`SPB_BANK0:
			begin
				case (offset)
					`SPB_OFS_DATA:
					begin
						next_rdata = rx_data; // R5
						wr_legal   = 1'b1;
					end
					`SPB_OFS_IER:
					begin
						next_rdata = irq_enable & ier_mask; // R10
						wr_legal   = 1'b1;
					end
					`SPB_OFS_EVT:
					begin
						next_rdata = event_ident; // R6
						wr_legal   = 1'b1;
					end
					`SPB_OFS_MCR:
					begin
						next_rdata = modem_mode_ctrl & mcr_mask;
						wr_legal   = 1'b1;
					end
					`SPB_OFS_LSR:
						next_rdata = link_status;
					`SPB_OFS_MSR:
						next_rdata = modem_status;
					`SPB_OFS_AUX:
					begin
						next_rdata = ext_mode ? aux_status : scratch_byte; // R11
						wr_legal   = 1'b1;
					end
					default:
						next_rdata = `SPB_RST_BYTE;
				endcase
			end
			`SPB_BANK1:
			begin
				case (offset)
					`SPB_OFS_DATA:
					begin
						next_rdata = legacy_divisor[7:0]; // R7
						wr_legal   = 1'b1;
					end
					`SPB_OFS_IER:
					begin
						next_rdata = legacy_divisor[15:8]; // R7
						wr_legal   = 1'b1;
					end
					default:
						next_rdata = `SPB_RST_BYTE; // R13
				endcase
			end
			`SPB_BANK2:
			begin
				case (offset)
					`SPB_OFS_DATA:
					begin
						next_rdata = ext_divisor[7:0]; // R8
						wr_legal   = 1'b1;
					end
					`SPB_OFS_IER:
					begin
						next_rdata = ext_divisor[15:8]; // R8
						wr_legal   = 1'b1;
					end
					`SPB_OFS_EVT:
					begin
						next_rdata = extended_ctrl_one; // R8
						wr_legal   = 1'b1;
					end
					`SPB_OFS_MCR:
					begin
						next_rdata = extended_ctrl_two; // R8
						wr_legal   = 1'b1;
					end
					`SPB_OFS_MSR:
						next_rdata = tx_fifo_level & `SPB_TX_FIFO_LEVEL_MASK; // R8
					`SPB_OFS_AUX:
						next_rdata = rx_fifo_level & `SPB_RX_FIFO_LEVEL_MASK; // R8
					default:
						next_rdata = `SPB_RST_BYTE; // R13
				endcase
			end
			`SPB_BANK3:
			begin
				// Identification and copies only; nothing here is writable
				case (offset)
					`SPB_OFS_DATA:
						next_rdata = {MODULE_ID, REVISION}; // R12
					`SPB_OFS_IER:
						next_rdata = {bank_select[`SPB_BANK_SELECT_FLAG_BIT], line_ctrl[6:0]}; // R9
					`SPB_OFS_EVT:
						next_rdata = fifo_ctrl; // R9
					default:
						next_rdata = `SPB_RST_BYTE; // R13
				endcase
			end
			default:
				// Infrared-only banks are not part of this block
				next_rdata = `SPB_RST_BYTE; // R13
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Slave handshake: waitrequest drops for one cycle, read data loads with it
always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		avs_waitrequest <= 1'b1;
		avs_readdata    <= 32'h0000_0000;
	end
	else
	begin
		avs_waitrequest <= ~(req & avs_waitrequest);
		if (avs_read && avs_waitrequest)
			avs_readdata <= {24'h00_0000, next_rdata};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register writes; illegal targets leave the registers unchanged and raise only the refused event
always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		bank_select       <= `SPB_RST_BYTE;
		line_ctrl         <= `SPB_RST_BYTE;
		scratch_byte      <= `SPB_RST_BYTE;
		aux_status_ctrl   <= `SPB_RST_BYTE;
		irq_enable        <= `SPB_RST_BYTE;
		modem_mode_ctrl   <= `SPB_RST_BYTE;
		fifo_ctrl         <= `SPB_RST_BYTE;
		tx_data           <= `SPB_RST_BYTE;
		legacy_divisor    <= `SPB_RST_WORD;
		ext_divisor       <= `SPB_RST_WORD;
		extended_ctrl_one <= `SPB_RST_BYTE;
		extended_ctrl_two <= `SPB_RST_BYTE;
	end
	else if (wr_take && wr_legal && !irq_area)
	begin
		if (offset == `SPB_OFS_LCBS)
		begin
			bank_select <= wbyte; // R2
			// With the flag set the byte is a selector, line settings stay
			if (!wbyte[`SPB_BANK_SELECT_FLAG_BIT])
				line_ctrl <= wbyte & `SPB_LINE_MASK; // R3
		end
		else
		begin
			case (bank)
				`SPB_BANK0:
				begin
					case (offset)
						`SPB_OFS_DATA:
							tx_data <= wbyte; // R5
						`SPB_OFS_IER:
							irq_enable <= wbyte & ier_mask; // R10
						`SPB_OFS_EVT:
							fifo_ctrl <= wbyte; // R6
						`SPB_OFS_MCR:
							modem_mode_ctrl <= wbyte & mcr_mask;
						`SPB_OFS_AUX:
						begin
							if (ext_mode)
								aux_status_ctrl <= wbyte; // R11
							else
								scratch_byte <= wbyte; // R11
						end
						default:
							scratch_byte <= scratch_byte;
					endcase
				end
				`SPB_BANK1:
				begin
					if (offset == `SPB_OFS_DATA)
						legacy_divisor[7:0] <= wbyte; // R7
					else
						legacy_divisor[15:8] <= wbyte; // R7
				end
				`SPB_BANK2:
				begin
					case (offset)
						`SPB_OFS_DATA:
							ext_divisor[7:0] <= wbyte; // R8
						`SPB_OFS_IER:
							ext_divisor[15:8] <= wbyte; // R8
						`SPB_OFS_EVT:
							extended_ctrl_one <= wbyte & `SPB_EXTENDED_CTRL_ONE_MASK; // R8
						`SPB_OFS_MCR:
							extended_ctrl_two <= wbyte & `SPB_EXTENDED_CTRL_TWO_MASK; // R8
						default:
							ext_divisor <= ext_divisor;
					endcase
				end
				default:
					scratch_byte <= scratch_byte;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Side-effect pulses to the UART core and event sources
always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
	begin
		rx_pop         <= 1'b0;
		tx_load        <= 1'b0;
		fifo_ctrl_load <= 1'b0;
		bank_write     <= 1'b0;
		tx_accepted    <= 1'b0;
		refused        <= 1'b0;
	end
	else
	begin
		// A data read consumes the byte, so a second read sees the next one
		rx_pop <= rd_take & ~irq_area & bank_valid & (bank == `SPB_BANK0)
			& (offset == `SPB_OFS_DATA); // R5
		tx_load <= wr_take & wr_legal & ~irq_area & (bank == `SPB_BANK0)
			& (offset == `SPB_OFS_DATA); // R5
		fifo_ctrl_load <= wr_take & wr_legal & ~irq_area & (bank == `SPB_BANK0)
			& (offset == `SPB_OFS_EVT); // R6
		bank_write <= wr_take & ~irq_area & (offset == `SPB_OFS_LCBS) & wbyte[`SPB_BANK_SELECT_FLAG_BIT];
		tx_accepted <= wr_take & wr_legal & ~irq_area & (bank == `SPB_BANK0)
			& (offset == `SPB_OFS_DATA);
		// Dropped writes are visible to software only as this event
		refused <= wr_take & ~wr_legal; // R13
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt status and mask

assign events[`SPB_EV_RX]      = rx_valid;
assign events[`SPB_EV_TX]      = tx_accepted;
assign events[`SPB_EV_BANK]    = bank_write;
assign events[`SPB_EV_REFUSED] = refused;

spb_irq u_irq
(
	.mclk     (mclk),
	.rst_b    (rst_b),
	.events   (events),
	.clear_wr (wr_take & (avs_address == `SPB_IDX_IRQ_STATUS)),
	.mask_wr  (wr_take & (avs_address == `SPB_IDX_IRQ_MASK)),
	.wr_data  (wbyte[`SPB_EV_W-1:0]),
	.status   (irq_status),
	.mask     (irq_mask),
	.irq      (irq_next)
);

// Output stage kept in this module so the interrupt pin is a local flop
always @(posedge mclk or negedge rst_b)
begin
	if (!rst_b)
		irq <= 1'b0;
	else
		irq <= irq_next;
end

endmodule
`default_nettype wire

// ### verif/spb_regs_sva.sv
// Checker for the register bank slave: handshake and side-effect timing.
// Assumes it is bound to spb_regs and sees only that module's ports.
`default_nettype none

module spb_regs_sva
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_b,
	// Avalon-MM slave
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Side effects
	input wire logic        rx_pop,
	input wire logic        tx_load,
	input wire logic        fifo_ctrl_load,
	input wire logic [7:0]  line_ctrl,
	input wire logic [15:0] legacy_divisor
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////////////
	// Completed transfers; pulses may trail them by one or two edges
	wire logic req   = avs_read | avs_write;
	wire logic wdone = avs_write & ~avs_waitrequest;
	wire logic rdone = avs_read & ~avs_waitrequest;
	wire logic lwr   = wdone & (avs_address == 4'h3) & ~avs_writedata[7];

	////////////////////////////////////////////////////////////////////////
	a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_needs_req: assert property (!avs_waitrequest |-> req && $past(req))
		else $error("waitrequest low without a held request");
	a_idle_keeps_wait: assert property (!req |=> avs_waitrequest)
		else $error("waitrequest dropped while idle");
	a_req_answered: assert property (req && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
		else $error("request not answered in two cycles");
	a_readdata_upper: assert property (avs_readdata[31:8] == 24'h00_0000)
		else $error("readdata upper bits not zero");
	a_tx_load_src: assert property (tx_load |-> ($past(wdone && avs_address == 4'h0)
		|| $past(wdone && avs_address == 4'h0, 2)) ##1 !tx_load) else $error("tx_load without data write");
	a_rx_pop_src: assert property (rx_pop |-> ($past(rdone && avs_address == 4'h0)
		|| $past(rdone && avs_address == 4'h0, 2)) ##1 !rx_pop) else $error("rx_pop without data read");
	a_fifo_load_src: assert property (fifo_ctrl_load |-> $past(wdone && avs_address == 4'h2)
		|| $past(wdone && avs_address == 4'h2, 2)) else $error("fifo_ctrl_load without write");
	a_line_ctrl_src: assert property ($changed(line_ctrl) |-> $past(lwr) || $past(lwr, 2))
		else $error("line_ctrl changed without line write");
	a_line_bit_low: assert property (line_ctrl[7] == 1'b0)
		else $error("line_ctrl bit 7 set");
	a_divisor_src: assert property ($changed(legacy_divisor) |-> $past(wdone && avs_address[3:1] == 3'h0)
		|| $past(wdone && avs_address[3:1] == 3'h0, 2)) else $error("divisor changed without write");
endmodule

bind spb_regs spb_regs_sva u_sva
(
	.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rx_pop(rx_pop), .tx_load(tx_load),
	.fifo_ctrl_load(fifo_ctrl_load), .line_ctrl(line_ctrl), .legacy_divisor(legacy_divisor)
);

`default_nettype wire

// ### verif/spb_core_model.sv
// Stand-in for the UART core: receive byte source and fixed status values.
// Assumes rx_pop and tx_load are one-cycle pulses on mclk.
`default_nettype none

module spb_core_model
(
	// Clock and reset
	input wire logic  mclk,
	input wire logic  rst_b,
	// Receive and transmit side
	input wire logic  rx_pop,
	input wire logic  tx_load,
	output logic [7:0] rx_data,
	output logic       rx_valid,
	// Status towards the bank
	output logic [7:0] event_ident,
	output logic [7:0] link_status,
	output logic [7:0] modem_status,
	output logic [7:0] aux_status,
	output logic [7:0] tx_fifo_level,
	output logic [7:0] rx_fifo_level
);
	timeunit 1ns;
	timeprecision 1ns;
	integer tx_count;

	////////////////////////////////////////////////////////////////////////
	// Levels all ones so that read masking shows
	assign event_ident   = 8'hc1;
	assign link_status   = 8'h60;
	assign modem_status  = 8'hb0;
	assign aux_status    = 8'h5a;
	assign tx_fifo_level = 8'hff;
	assign rx_fifo_level = 8'hff;

	// Each pop brings the next byte, whose arrival is the receive event
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_data <= 8'h3c;
			rx_valid <= 1'b0;
			tx_count <= 0;
		end
		else
		begin
			rx_valid <= rx_pop;
			if (rx_pop)
				rx_data <= rx_data + 8'h11;
			if (tx_load)
				tx_count <= tx_count + 1;
		end
	end
endmodule

`default_nettype wire

// ### verif/serial_port_register_banks_test.sv
// Self-checking bench for the serial port register banks over Avalon-MM.
// Assumes spb_regs, its checker and the core stand-in are compiled first.
`default_nettype none

module serial_port_register_banks_test;
	timeunit 1ns;
	timeprecision 1ns;
	// Bus drive
	logic mclk, rst_b, avs_read, avs_write;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata;
	// Design outputs
	wire logic [31:0] avs_readdata;
	wire logic        avs_waitrequest, irq, rx_pop, rx_valid, tx_load, fifo_ctrl_load;
	wire logic [7:0]  rx_data, tx_data, fifo_ctrl, tx_fifo_level, rx_fifo_level, event_ident;
	wire logic [7:0]  link_status, modem_status, aux_status, line_ctrl, irq_enable, modem_mode_ctrl;
	wire logic [7:0]  aux_status_ctrl, extended_ctrl_one, extended_ctrl_two;
	wire logic [15:0] legacy_divisor, ext_divisor;
	// Bench model state
	integer     n_errors, check_count, k;
	logic [7:0] q, r0, r1, rx_exp;
	logic [7:0] sels [9];
	logic [7:0] off0 [9];

	spb_regs dut
	(
		.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(4'h1), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_pop(rx_pop), .tx_data(tx_data), .tx_load(tx_load),
		.fifo_ctrl(fifo_ctrl), .fifo_ctrl_load(fifo_ctrl_load), .tx_fifo_level(tx_fifo_level),
		.rx_fifo_level(rx_fifo_level), .event_ident(event_ident), .link_status(link_status),
		.modem_status(modem_status), .aux_status(aux_status), .line_ctrl(line_ctrl),
		.irq_enable(irq_enable), .modem_mode_ctrl(modem_mode_ctrl), .aux_status_ctrl(aux_status_ctrl),
		.legacy_divisor(legacy_divisor), .ext_divisor(ext_divisor),
		.extended_ctrl_one(extended_ctrl_one), .extended_ctrl_two(extended_ctrl_two)
	);

	spb_core_model u_core
	(
		.mclk(mclk), .rst_b(rst_b), .rx_pop(rx_pop), .tx_load(tx_load), .rx_data(rx_data),
		.rx_valid(rx_valid), .event_ident(event_ident), .link_status(link_status),
		.modem_status(modem_status), .aux_status(aux_status), .tx_fifo_level(tx_fifo_level),
		.rx_fifo_level(rx_fifo_level)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task results;
	begin
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	begin
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	end
	endtask

	// One Avalon transfer; held until waitrequest is sampled low
	task av(input logic w, input logic [3:0] a, input logic [7:0] d);
		integer i;
	begin
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= w;
		avs_read <= ~w;
		i = 0;
		do begin @(posedge mclk); i++; end while (avs_waitrequest !== 1'b0 && i < 40);
		if (i >= 40)
		begin
			n_errors++;
			results();
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	end
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		av(1'b1, a, d);
	endtask

	task rc(input logic [3:0] a, input logic [7:0] e);
	begin
		av(1'b0, a, 8'h00);
		chk("readdata", {8'h00, e}, {8'h00, q});
	end
	endtask

	// Lets registered side effects land before ports are looked at
	task settle;
		repeat (3) @(posedge mclk);
	endtask

	task wirq(input logic v);
		integer i;
	begin
		i = 0;
		while (irq !== v && i < 20) begin @(posedge mclk); i++; end
		chk("irq", {15'h0000, v}, {15'h0000, irq});
		if (irq !== v)
			results();
	end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		n_errors = 0;
		check_count = 0;
		rst_b = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		sels = '{8'h80, 8'hbf, 8'hc2, 8'hc1, 8'he0, 8'he4, 8'he8, 8'hf4, 8'hc0};
		off0 = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h10, 8'h00, 8'h00, 8'h00};
		void'($urandom(70256));
		r0 = $urandom;
		r1 = $urandom;
		rx_exp = 8'h3c;
		repeat (5) @(posedge mclk);
		rst_b <= 1'b1;
		rc(4'h3, 8'h00);
		rc(4'h1, 8'h00);
		rc(4'h9, 8'h00);
		wr(4'h3, 8'h1b);
		rc(4'h3, 8'h1b);
		wr(4'h1, 8'hff);
		rc(4'h1, 8'h0f);
		wr(4'h7, r0);
		rc(4'h7, r0);
		wr(4'h0, r1);
		rc(4'h0, rx_exp);
		rx_exp = rx_exp + 8'h11;
		rc(4'h2, 8'hc1);
		wr(4'h2, 8'hc7);
		rc(4'h5, 8'h60);
		rc(4'h6, 8'hb0);
		// Modem/mode control keeps only its standard-mode bits
		wr(4'h4, 8'hff);
		rc(4'h4, 8'h1f);
		settle();
		chk("tx_data", {8'h00, r1}, {8'h00, tx_data});
		chk("fifo_ctrl", 16'h00c7, {8'h00, fifo_ctrl});
		// Flagged selectors for banks 1 to 4, bank 7 and an undecoded code, then what offset 0 holds in that bank
		for (k = 0; k < 9; k++)
		begin
			wr(4'h3, sels[k]);
			rc(4'h3, sels[k]);
			wr(4'h0, 8'h55);
			rc(4'h0, off0[k]);
		end
		chk("line_ctrl", 16'h001b, {8'h00, line_ctrl});
		wr(4'h3, 8'h80);
		wr(4'h1, r0);
		rc(4'h2, 8'h00);
		wr(4'h4, 8'hff);
		rc(4'h4, 8'h00);
		settle();
		chk("legacy_divisor", {r0, 8'h55}, legacy_divisor);
		wr(4'h3, 8'he0);
		wr(4'h1, r1);
		wr(4'h2, 8'hff);
		rc(4'h2, 8'hb1);
		wr(4'h4, 8'hff);
		rc(4'h4, 8'hb0);
		rc(4'h6, 8'h3f);
		rc(4'h7, 8'h1f);
		rc(4'h5, 8'h00);
		settle();
		chk("ext_divisor", {r1, 8'h55}, ext_divisor);
		wr(4'h3, 8'he4);
		rc(4'h0, 8'h10);
		rc(4'h1, 8'h9b);
		rc(4'h2, 8'hc7);
		rc(4'h6, 8'h00);
		wr(4'h3, 8'h1b);
		wr(4'h1, 8'hff);
		rc(4'h1, 8'h2f);
		rc(4'h7, 8'h5a);
		// Extended mode narrows modem/mode control, offset 7 writes go to aux control
		wr(4'h4, 8'hff);
		rc(4'h4, 8'h0b);
		chk("modem_mode_ctrl", 16'h000b, {8'h00, modem_mode_ctrl});
		wr(4'h7, r1);
		rc(4'h7, 8'h5a);
		chk("aux_status_ctrl", {8'h00, r1}, {8'h00, aux_status_ctrl});
		chk("scratch_byte", {8'h00, r0}, {8'h00, dut.scratch_byte});
		// Sticky status, mask and clear
		wr(4'h9, 8'h0f);
		wr(4'h8, 8'h0f);
		rc(4'h8, 8'h00);
		wirq(1'b0);
		wr(4'h3, 8'he4);
		wr(4'h0, 8'hff);
		wirq(1'b1);
		rc(4'h8, 8'h0c);
		wr(4'h9, 8'h00);
		wirq(1'b0);
		wr(4'h8, 8'h0f);
		rc(4'h8, 8'h00);
		wr(4'h3, 8'h1b);
		rc(4'h0, rx_exp);
		wr(4'h0, r0);
		settle();
		rc(4'h8, 8'h03);
		wr(4'h9, 8'h01);
		wirq(1'b1);
		wr(4'h8, 8'h01);
		wirq(1'b0);
		chk("tx_count", 16'h0002, u_core.tx_count[15:0]);
		wr(4'hc, 8'hff);
		rc(4'hc, 8'h00);
		// Mid-run reset returns the bank to its power-up state
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("line_ctrl", 16'h0000, {8'h00, line_ctrl});
		chk("legacy_divisor", 16'h0000, legacy_divisor);
		chk("irq", 16'h0000, {15'h0000, irq});
		rst_b <= 1'b1;
		rc(4'h3, 8'h00);
		rc(4'h8, 8'h00);
		rc(4'h1, 8'h00);
		results();
	end
endmodule

`default_nettype wire
